//--- design/dob_host.sv
`timescale 1ns/10ps
`default_nettype none
module dob_host (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             msg_valid_out,
  output logic [31:0]      msg_data_out,
  output logic             msg_last_out,
  input  wire logic        msg_ready_in,
  input  wire logic        wb_valid_in,
  input  wire logic [31:0] wb_data_in
);

  typedef struct packed {
    dob_pkg::dob_state_t state;
    logic [3:0]          mode;
    logic [31:0]         off0;
    logic [31:0]         off1;
    logic [31:0]         xoff;
    logic [31:0]         yoff;
    logic [31:0]         sbase;
    logic [31:0]         sdim;
    logic [5:0]          blk_w;
    logic [6:0]          blk_h;
    logic [12:0]         surf;
    logic                done;
    logic [3:0]          err;
    logic                stride_valid;
    logic                stride_last;
    logic [5:0]          idx;
    logic [5:0]          last_idx;
    logic [5:0]          wb_cnt;
    logic [5:0]          wb_total;
    logic [31:0][31:0]   dbuf;
    logic [31:0]         rdata;
    logic                mvalid;
    logic [31:0]         mdata;
    logic                mlast;
  } dob_regs_t;

  dob_regs_t  s;
  dob_regs_t  next_s;
  logic [3:0] chk_err;
  logic [2:0] chk_regs;
  logic       busy;
  logic       start_req;

  dob_req_check u_check (
    .media_in        (s.mode[dob_pkg::MODE_MEDIA]),
    .write_in        (s.mode[dob_pkg::MODE_WRITE]),
    .bsz_in          (s.mode[dob_pkg::MODE_BSZ_LSB +: 2]),
    .off0_in         (s.off0),
    .off1_in         (s.off1),
    .xoff_in         (s.xoff),
    .yoff_in         (s.yoff),
    .blk_w_in        (s.blk_w),
    .blk_h_in        (s.blk_h),
    .surf_in         (s.surf),
    .sbase_in        (s.sbase),
    .sdim_in         (s.sdim),
    .stride_valid_in (s.stride_valid),
    .stride_last_in  (s.stride_last),
    .err_out         (chk_err),
    .regs_out        (chk_regs)
  );

  function automatic logic [31:0] msg_word(input dob_regs_t r, input logic [5:0] i);
    logic [31:0] w;
    logic [5:0]  j;
    logic [5:0]  k;
    logic [6:0]  hm;
    logic [5:0]  wm;
    logic        med;
    w   = 32'h0000_0000;
    j   = i - 6'h01;
    k   = i - dob_pkg::IDX_DATA;
    hm  = r.blk_h - 7'h01;
    wm  = r.blk_w - 6'h01;
    med = r.mode[dob_pkg::MODE_MEDIA];
    if (i == dob_pkg::IDX_DESC) begin
      w[dob_pkg::DESC_WRITE]  = r.mode[dob_pkg::MODE_WRITE];
      w[dob_pkg::DESC_MEDIA]  = med;
      w[dob_pkg::DESC_COLOUR] = med & r.surf[dob_pkg::SURF_COLOUR];
      w[dob_pkg::DESC_STRIDE] = med & r.surf[dob_pkg::SURF_STRIDE];
      if (!med) begin
        w[dob_pkg::DESC_BSZ_LSB +: 2] = r.mode[dob_pkg::MODE_BSZ_LSB +: 2];
      end
    end else if (i <= dob_pkg::IDX_HDR_LAST) begin
      if (!med) begin
        // offsets at dwords zero and four.
        if (j == 6'h00) begin
          w = r.off0;
        end else if (j == 6'h04) begin
          w = r.off1;
        end
      end else if (j == 6'h00) begin
        w = r.xoff;
      end else if (j == 6'h01) begin
        w = r.yoff;
      end else if (j == 6'h02) begin
        w[dob_pkg::HDR_H_LSB +: 6] = hm[5:0];
        w[dob_pkg::HDR_W_LSB +: 5] = wm[4:0];
      end
    end else begin
      w = r.dbuf[k[4:0]];
    end
    return w;
  endfunction : msg_word

  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0000_0000;
    busy         = (s.state != dob_pkg::ST_IDLE);
    start_req    = reg_wr_in && (reg_addr_in == dob_pkg::REG_CTRL) &&
                   reg_wdata_in[dob_pkg::CTRL_START] && !busy;
    if (reg_rd_in) begin
      if (reg_addr_in[7]) begin
        next_s.rdata = s.dbuf[reg_addr_in[6:2]];
      end else begin
        case (reg_addr_in)
          dob_pkg::REG_MODE:   next_s.rdata = {28'h0000000, s.mode};
          dob_pkg::REG_OFF0:   next_s.rdata = s.off0;
          dob_pkg::REG_OFF1:   next_s.rdata = s.off1;
          dob_pkg::REG_XOFF:   next_s.rdata = s.xoff;
          dob_pkg::REG_YOFF:   next_s.rdata = s.yoff;
          dob_pkg::REG_BLOCK:  next_s.rdata = {17'h00000, s.blk_h, 2'h0, s.blk_w};
          dob_pkg::REG_SURF:   next_s.rdata = {19'h00000, s.surf};
          dob_pkg::REG_SBASE:  next_s.rdata = s.sbase;
          dob_pkg::REG_SDIM:   next_s.rdata = s.sdim;
          dob_pkg::REG_STATUS: next_s.rdata = {24'h000000, s.err, 1'b0, s.stride_valid,
                                               s.done, busy};
          default:             next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (reg_wr_in && (reg_addr_in == dob_pkg::REG_CTRL)) begin
      if (reg_wdata_in[dob_pkg::CTRL_CLR]) begin
        next_s.done = 1'b0;
      end
      if (reg_wdata_in[dob_pkg::CTRL_FLUSH] && !busy) begin
        next_s.stride_valid = 1'b0;
      end
    end
    if (reg_wr_in && !busy) begin
      if (reg_addr_in[7]) begin
        next_s.dbuf[reg_addr_in[6:2]] = reg_wdata_in;
      end else begin
        case (reg_addr_in)
          dob_pkg::REG_MODE:  next_s.mode  = reg_wdata_in[3:0];
          dob_pkg::REG_OFF0:  next_s.off0  = reg_wdata_in;
          dob_pkg::REG_OFF1:  next_s.off1  = reg_wdata_in;
          dob_pkg::REG_XOFF:  next_s.xoff  = reg_wdata_in;
          dob_pkg::REG_YOFF:  next_s.yoff  = reg_wdata_in;
          dob_pkg::REG_BLOCK: begin
            next_s.blk_w = reg_wdata_in[dob_pkg::BLK_W_LSB +: 6];
            next_s.blk_h = reg_wdata_in[dob_pkg::BLK_H_LSB +: 7];
          end
          dob_pkg::REG_SURF:  next_s.surf  = reg_wdata_in[12:0];
          dob_pkg::REG_SBASE: next_s.sbase = reg_wdata_in;
          dob_pkg::REG_SDIM:  next_s.sdim  = reg_wdata_in;
          default: ;
        endcase
      end
    end
    case (s.state)
      dob_pkg::ST_IDLE: begin
        if (start_req) begin
          next_s.done = 1'b0;
          next_s.err  = chk_err;
          if (chk_err != dob_pkg::ERR_NONE) begin
            next_s.done = 1'b1;
          end else begin
            next_s.state    = dob_pkg::ST_SEND;
            next_s.idx      = dob_pkg::IDX_DESC;
            next_s.mvalid   = 1'b1;
            next_s.mdata    = msg_word(s, dob_pkg::IDX_DESC);
            next_s.mlast    = 1'b0;
            next_s.wb_cnt   = 6'h00;
            next_s.wb_total = {chk_regs, 3'h0};
            next_s.last_idx = dob_pkg::IDX_HDR_LAST +
                              (s.mode[dob_pkg::MODE_WRITE] ? {chk_regs, 3'h0} : 6'h00);
            if (s.mode[dob_pkg::MODE_MEDIA] && s.surf[dob_pkg::SURF_TILED] &&
                s.surf[dob_pkg::SURF_XMAJOR]) begin
              next_s.stride_valid = 1'b1;
              next_s.stride_last  = s.surf[dob_pkg::SURF_STRIDE];
            end
          end
        end
      end
      dob_pkg::ST_SEND: begin
        if (msg_ready_in) begin
          if (s.idx == s.last_idx) begin
            next_s.mvalid = 1'b0;
            next_s.mlast  = 1'b0;
            if (s.mode[dob_pkg::MODE_WRITE]) begin
              next_s.state = dob_pkg::ST_IDLE;
              next_s.done  = 1'b1;
            end else begin
              next_s.state = dob_pkg::ST_WAIT;
            end
          end else begin
            next_s.idx   = s.idx + 6'h01;
            next_s.mdata = msg_word(s, s.idx + 6'h01);
            next_s.mlast = ((s.idx + 6'h01) == s.last_idx);
          end
        end
      end
      dob_pkg::ST_WAIT: begin
        if (wb_valid_in) begin
          next_s.dbuf[s.wb_cnt[4:0]] = wb_data_in;
          next_s.wb_cnt              = s.wb_cnt + 6'h01;
          if (s.wb_cnt == (s.wb_total - 6'h01)) begin
            next_s.state = dob_pkg::ST_IDLE;
            next_s.done  = 1'b1;
          end
        end
      end
      default: next_s.state = dob_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign msg_valid_out = s.mvalid;
  assign msg_data_out  = s.mdata;
  assign msg_last_out  = s.mlast;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence seq_dual_launch;
    start_req && (chk_err == dob_pkg::ERR_NONE) && !s.mode[dob_pkg::MODE_MEDIA];
  endsequence
  sequence seq_desc_out;
    msg_valid_out && (s.idx == dob_pkg::IDX_DESC) && !msg_last_out;
  endsequence
  sequence seq_media_desc;
    msg_valid_out && (s.idx == dob_pkg::IDX_DESC) && msg_data_out[dob_pkg::DESC_MEDIA];
  endsequence

  a_bsize_legal: assert property (
    seq_dual_launch |=> seq_desc_out ##0 (msg_data_out[9:8] == 2'h0 || msg_data_out[9:8] == 2'h2))
    else $error("Reserved block size sent.");
  a_offset_aligned: assert property (
    msg_valid_out && !s.mode[dob_pkg::MODE_MEDIA] && (s.idx == 6'h01 || s.idx == 6'h05)
    |-> msg_data_out[3:0] == 4'h0)
    else $error("Unaligned block offset sent.");
  a_dual_span: assert property (
    msg_valid_out && msg_ready_in && msg_last_out && !s.mode[dob_pkg::MODE_MEDIA] &&
    s.mode[dob_pkg::MODE_WRITE]
    |-> s.idx == ((s.mode[dob_pkg::MODE_BSZ_LSB +: 2] == dob_pkg::BSZ_FOUR) ? 6'h28 : 6'h10))
    else $error("Dual write data span wrong.");
  a_media_surface: assert property (
    seq_media_desc |-> s.surf[dob_pkg::SURF_IS2D] && !s.surf[dob_pkg::SURF_ARRMIP])
    else $error("Media block on wrong surface.");
  a_media_cache: assert property (
    seq_media_desc |-> !s.surf[dob_pkg::SURF_DCACHE] && (s.sbase[4:0] == 5'h00))
    else $error("Media block cache or base illegal.");
  a_write_xalign: assert property (
    msg_valid_out && s.mode[dob_pkg::MODE_MEDIA] && s.mode[dob_pkg::MODE_WRITE] &&
    (s.idx == 6'h01) |-> msg_data_out[1:0] == 2'h0 && s.blk_w[1:0] == 2'h0)
    else $error("Media write not DWord aligned.");
  a_stride_mix: assert property (
    seq_media_desc ##0 (s.surf[dob_pkg::SURF_TILED] && s.surf[dob_pkg::SURF_XMAJOR])
    |-> s.stride_valid && (msg_data_out[dob_pkg::DESC_STRIDE] == s.stride_last))
    else $error("Stride mode mixed without flush.");
  a_colour_tiled: assert property (
    seq_media_desc ##0 (msg_data_out[dob_pkg::DESC_COLOUR] && msg_data_out[dob_pkg::DESC_WRITE])
    |-> s.surf[dob_pkg::SURF_TILED])
    else $error("Colour write to untiled surface.");
  a_420_yeven: assert property (
    msg_valid_out && s.mode[dob_pkg::MODE_MEDIA] && s.mode[dob_pkg::MODE_WRITE] &&
    s.surf[dob_pkg::SURF_COLOUR] && s.surf[dob_pkg::SURF_OUT420] && (s.idx == 6'h02)
    |-> msg_data_out[0] == 1'b0)
    else $error("Odd row for subsampled output.");
  a_420_shape: assert property (
    seq_media_desc ##0 (msg_data_out[dob_pkg::DESC_COLOUR] && msg_data_out[dob_pkg::DESC_WRITE] &&
    s.surf[dob_pkg::SURF_OUT420])
    |-> !s.blk_h[0] && (s.surf[dob_pkg::SURF_INFMT_LSB +: 2] != dob_pkg::IN_444_16))
    else $error("Illegal subsampled block shape.");
  a_hdr_encode: assert property (
    msg_valid_out && s.mode[dob_pkg::MODE_MEDIA] && (s.idx == 6'h03)
    |-> ({1'b0, msg_data_out[21:16]} + 7'h01 == s.blk_h) &&
        ({1'b0, msg_data_out[4:0]} + 6'h01 == s.blk_w))
    else $error("Header shape encoding wrong.");
  a_pixel_align: assert property (
    seq_media_desc ##0 (s.surf[dob_pkg::SURF_PIX_LSB +: 3] == dob_pkg::PIX_WORD)
    |-> !s.xoff[0] && !s.blk_w[0])
    else $error("Word pixel block misaligned.");

endmodule : dob_host
`default_nettype wire

//--- design/dob_pkg.sv
package dob_pkg;

  // Register byte addresses on the command port.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MODE   = 8'h04;
  localparam logic [7:0] REG_OFF0   = 8'h08;
  localparam logic [7:0] REG_OFF1   = 8'h0c;
  localparam logic [7:0] REG_XOFF   = 8'h10;
  localparam logic [7:0] REG_YOFF   = 8'h14;
  localparam logic [7:0] REG_BLOCK  = 8'h18;
  localparam logic [7:0] REG_SURF   = 8'h1c;
  localparam logic [7:0] REG_SBASE  = 8'h20;
  localparam logic [7:0] REG_SDIM   = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;

  // Control bits.
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_FLUSH = 1;
  localparam int unsigned CTRL_CLR   = 2;

  // Mode fields.
  localparam int unsigned MODE_MEDIA   = 0;
  localparam int unsigned MODE_WRITE   = 1;
  localparam int unsigned MODE_BSZ_LSB = 2;
  localparam logic [1:0]  BSZ_ONE      = 2'h0;
  localparam logic [1:0]  BSZ_FOUR     = 2'h2;

  // Block shape fields: width in bytes 1..32, height in rows 1..64.
  localparam int unsigned BLK_W_LSB = 0;
  localparam int unsigned BLK_H_LSB = 8;

  // Surface fields.
  localparam int unsigned SURF_PIX_LSB   = 0;
  localparam int unsigned SURF_COLOUR    = 3;
  localparam int unsigned SURF_TILED     = 4;
  localparam int unsigned SURF_XMAJOR    = 5;
  localparam int unsigned SURF_IS2D      = 6;
  localparam int unsigned SURF_ARRMIP    = 7;
  localparam int unsigned SURF_DCACHE    = 8;
  localparam int unsigned SURF_STRIDE    = 9;
  localparam int unsigned SURF_OUT420    = 10;
  localparam int unsigned SURF_INFMT_LSB = 11;
  localparam int unsigned SDIM_H_LSB     = 16;

  // Pixel kinds of the target surface.
  localparam logic [2:0] PIX_BYTE                    = 3'h0;
  localparam logic [2:0] PIX_WORD                    = 3'h1;
  localparam logic [2:0] PIX_LUMA_FIRST_PACKED_ORDER = 3'h2;
  localparam logic [2:0] PIX_CHROMA_FIRST_PACKED     = 3'h3;
  localparam logic [2:0] PIX_DWORD                   = 3'h4;

  // Colour-stage input formats.
  localparam logic [1:0] IN_422_8  = 2'h0;
  localparam logic [1:0] IN_422_16 = 2'h1;
  localparam logic [1:0] IN_444_8  = 2'h2;
  localparam logic [1:0] IN_444_16 = 2'h3;

  // Status bits.
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_DONE    = 1;
  localparam int unsigned STAT_STRIDE  = 2;
  localparam int unsigned STAT_ERR_LSB = 4;

  // Descriptor and header layout of the outgoing message.
  localparam int unsigned DESC_BSZ_LSB = 8;
  localparam int unsigned DESC_STRIDE  = 10;
  localparam int unsigned DESC_WRITE   = 16;
  localparam int unsigned DESC_MEDIA   = 17;
  localparam int unsigned DESC_COLOUR  = 18;
  localparam int unsigned HDR_W_LSB    = 0;
  localparam int unsigned HDR_H_LSB    = 16;
  localparam logic [5:0]  IDX_DESC     = 6'h00;
  localparam logic [5:0]  IDX_HDR_LAST = 6'h08;
  localparam logic [5:0]  IDX_DATA     = 6'h09;
  localparam logic [11:0] BUF_BYTES    = 12'h080;

  // Refusal codes.
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_BSIZE  = 4'h1;
  localparam logic [3:0] ERR_OALIGN = 4'h2;
  localparam logic [3:0] ERR_SURF   = 4'h3;
  localparam logic [3:0] ERR_CACHE  = 4'h4;
  localparam logic [3:0] ERR_SHAPE  = 4'h5;
  localparam logic [3:0] ERR_WALIGN = 4'h6;
  localparam logic [3:0] ERR_PALIGN = 4'h7;
  localparam logic [3:0] ERR_STRIDE = 4'h8;
  localparam logic [3:0] ERR_TILE   = 4'h9;
  localparam logic [3:0] ERR_420POS = 4'ha;
  localparam logic [3:0] ERR_420BLK = 4'hb;
  localparam logic [3:0] ERR_SIZE   = 4'hc;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} dob_state_t;

endpackage : dob_pkg

//--- design/dob_req_check.sv
`timescale 1ns/10ps
`default_nettype none
module dob_req_check (
  input  wire logic        media_in,
  input  wire logic        write_in,
  input  wire logic [1:0]  bsz_in,
  input  wire logic [31:0] off0_in,
  input  wire logic [31:0] off1_in,
  input  wire logic [31:0] xoff_in,
  input  wire logic [31:0] yoff_in,
  input  wire logic [5:0]  blk_w_in,
  input  wire logic [6:0]  blk_h_in,
  input  wire logic [12:0] surf_in,
  input  wire logic [31:0] sbase_in,
  input  wire logic [31:0] sdim_in,
  input  wire logic        stride_valid_in,
  input  wire logic        stride_last_in,
  output logic [3:0]       err_out,
  output logic [2:0]       regs_out
);
  logic [5:0]  pitch;
  logic [11:0] bytes;
  logic [11:0] regs_wide;
  logic [2:0]  pix;
  logic [1:0]  infmt;
  logic        mis_pix;
  logic        bad_pos;
  logic        bad_blk;

  always_comb begin
    pix   = surf_in[dob_pkg::SURF_PIX_LSB +: 3];
    infmt = surf_in[dob_pkg::SURF_INFMT_LSB +: 2];
    if (blk_w_in <= 6'h01) begin
      pitch = 6'h01;
    end else if (blk_w_in <= 6'h02) begin
      pitch = 6'h02;
    end else if (blk_w_in <= 6'h04) begin
      pitch = 6'h04;
    end else if (blk_w_in <= 6'h08) begin
      pitch = 6'h08;
    end else if (blk_w_in <= 6'h10) begin
      pitch = 6'h10;
    end else begin
      pitch = 6'h20;
    end
    bytes     = {6'h00, pitch} * {5'h00, blk_h_in};
    regs_wide = (bytes + 12'h01f) >> 5;
    case (pix)
      dob_pkg::PIX_WORD: mis_pix = xoff_in[0] | blk_w_in[0];
      dob_pkg::PIX_LUMA_FIRST_PACKED_ORDER,
      dob_pkg::PIX_CHROMA_FIRST_PACKED,
      dob_pkg::PIX_DWORD: mis_pix = (|xoff_in[1:0]) | (|blk_w_in[1:0]);
      default: mis_pix = 1'b0;
    endcase
    bad_pos = yoff_in[0] | (|sdim_in[1:0]) | sdim_in[dob_pkg::SDIM_H_LSB] |
              ((infmt == dob_pkg::IN_422_8) ? (|xoff_in[2:0]) : (|xoff_in[3:0]));
    bad_blk = blk_h_in[0] | (infmt == dob_pkg::IN_444_16) |
              ((infmt == dob_pkg::IN_422_8) ? (blk_w_in != 6'h10 && blk_w_in != 6'h08)
                                            : (blk_w_in != 6'h10));
    err_out  = dob_pkg::ERR_NONE;
    regs_out = 3'h1;
    if (!media_in) begin
      regs_out = (bsz_in == dob_pkg::BSZ_FOUR) ? 3'h4 : 3'h1;
      if (bsz_in != dob_pkg::BSZ_ONE && bsz_in != dob_pkg::BSZ_FOUR) begin
        err_out = dob_pkg::ERR_BSIZE;
      end else if ((|off0_in[3:0]) || (|off1_in[3:0])) begin
        err_out = dob_pkg::ERR_OALIGN;
      end
    end else begin
      regs_out = regs_wide[2:0];
      if (!surf_in[dob_pkg::SURF_IS2D] || surf_in[dob_pkg::SURF_ARRMIP]) begin
        err_out = dob_pkg::ERR_SURF;
      end else if (surf_in[dob_pkg::SURF_DCACHE] || (|sbase_in[4:0])) begin
        err_out = dob_pkg::ERR_CACHE;
      end else if (blk_w_in == 6'h00 || blk_w_in > 6'h20 ||
                   blk_h_in == 7'h00 || blk_h_in > 7'h40) begin
        err_out = dob_pkg::ERR_SHAPE;
      end else if (write_in && ((|xoff_in[1:0]) || (|blk_w_in[1:0]))) begin
        err_out = dob_pkg::ERR_WALIGN;
      end else if (mis_pix) begin
        err_out = dob_pkg::ERR_PALIGN;
      end else if (surf_in[dob_pkg::SURF_TILED] && surf_in[dob_pkg::SURF_XMAJOR] &&
                   stride_valid_in && (surf_in[dob_pkg::SURF_STRIDE] != stride_last_in)) begin
        err_out = dob_pkg::ERR_STRIDE;
      end else if (write_in && surf_in[dob_pkg::SURF_COLOUR] && !surf_in[dob_pkg::SURF_TILED]) begin
        err_out = dob_pkg::ERR_TILE;
      end else if (write_in && surf_in[dob_pkg::SURF_COLOUR] &&
                   surf_in[dob_pkg::SURF_OUT420] && bad_pos) begin
        err_out = dob_pkg::ERR_420POS;
      end else if (write_in && surf_in[dob_pkg::SURF_COLOUR] &&
                   surf_in[dob_pkg::SURF_OUT420] && bad_blk) begin
        err_out = dob_pkg::ERR_420BLK;
      end else if (bytes > dob_pkg::BUF_BYTES) begin
        err_out = dob_pkg::ERR_SIZE;
      end
    end
  end

endmodule : dob_req_check
`default_nettype wire

//--- dv/dob_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module dob_dev_model (
  input  wire logic        ref_clk_in,
  input  wire logic        stall_in,
  input  wire logic        msg_valid_in,
  input  wire logic [31:0] msg_data_in,
  input  wire logic        msg_last_in,
  output logic             msg_ready_out = 1'b0,
  output logic             wb_valid_out = 1'b0,
  output logic [31:0]      wb_data_out = 32'h0
);
  logic [31:0] cap [0:63];
  int          n = 0;
  int          nmsg = 0;
  int          left = 0;
  int          idx = 0;
  logic        in_msg = 1'b0;
  // Stalls on every other cycle when asked to.
  always @(posedge ref_clk_in) begin
    msg_ready_out <= !stall_in || !msg_ready_out;
    wb_valid_out <= left > 0;
    // raw words returned, no mask applied.
    // tag a5 in the top byte, running word index idx in the low byte
    wb_data_out <= (left > 0) ? {8'ha5, 16'h0, 8'(idx)} : ~wb_data_out;
    if (left > 0) begin
      left <= left - 1;
      idx <= idx + 1;
    end
    if (msg_valid_in && msg_ready_out) begin
      cap[in_msg ? n : 0] <= msg_data_in;
      n <= in_msg ? n + 1 : 1;
      in_msg <= !msg_last_in;
      if (msg_last_in) begin
        nmsg <= nmsg + 1;
      end
      // reads return one or four registers
      if (msg_last_in && !cap[0][16]) begin
        left <= (cap[0][17] || !cap[0][9]) ? 8 : 32;
        idx <= 0;
      end
    end
  end
endmodule : dob_dev_model
`default_nettype wire

//--- dv/tb_dob_host.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dob_host;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] rdata, md, wd, v;
  logic        mv, ml, mr, wv;
  int          num_errors = 0;
  int          n_checks = 0;
  int          i;
  always #50 ref_clk_in = ~ref_clk_in;
  dob_host dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .msg_valid_out(mv), .msg_data_out(md), .msg_last_out(ml), .msg_ready_in(mr),
    .wb_valid_in(wv), .wb_data_in(wd));
  dob_dev_model dev_u (.ref_clk_in(ref_clk_in), .stall_in(stall), .msg_valid_in(mv),
    .msg_data_in(md), .msg_last_in(ml), .msg_ready_out(mr), .wb_valid_out(wv),
    .wb_data_out(wd));
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk_in);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic try(input logic [31:0] m, s, b, o, x, input logic [3:0] e);
    logic [31:0] st;
    int c;
    wr(dob_pkg::REG_MODE, m);
    wr(dob_pkg::REG_SURF, s);
    wr(dob_pkg::REG_SBASE, b);
    wr(dob_pkg::REG_OFF0, o);
    wr(dob_pkg::REG_XOFF, x);
    c = dev_u.nmsg;
    wr(dob_pkg::REG_CTRL, 32'h1);
    for (int k = 0; k < 300 && st[1] !== 1'b1; k++) rd(dob_pkg::REG_STATUS, st);
    chk("done", 32'h1, {31'h0, st[1]});
    chk("error code", {28'h0, e}, {28'h0, st[7:4]});
    chk("message count", 32'(c + int'(e == 4'h0)), 32'(dev_u.nmsg));
  endtask : try
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd(dob_pkg::REG_STATUS, v);
    chk("status", 32'h0, v);
    rd(8'h30, v);
    chk("unmapped", 32'h0, v);
    wr(dob_pkg::REG_BLOCK, 32'h804);
    wr(dob_pkg::REG_YOFF, 32'h6);
    wr(dob_pkg::REG_SDIM, 32'h400040);
    wr(dob_pkg::REG_OFF1, 32'h230);
    for (i = 0; i < 8; i++) wr(8'h80 + 8'(4 * i), 32'h1000 + i);
    stall <= 1'b1;
    try(32'h2, 32'h40, 32'h40, 32'h100, 32'h0, dob_pkg::ERR_NONE);
    chk("length", 32'd17, 32'(dev_u.n));
    chk("descriptor", 32'h10000, dev_u.cap[0] & 32'h70700);
    chk("offset 0", 32'h100, dev_u.cap[1]);
    chk("offset 1", 32'h230, dev_u.cap[5]);
    for (i = 0; i < 8; i++) chk("data", 32'h1000 + i, dev_u.cap[9 + i]);
    stall <= 1'b0;
    try(32'h8, 32'h40, 32'h40, 32'h100, 32'h0, dob_pkg::ERR_NONE);
    chk("descriptor", 32'h200, dev_u.cap[0] & 32'h70700);
    for (i = 0; i < 32; i++) begin
      rd(8'h80 + 8'(4 * i), v);
      chk("writeback", {8'ha5, 16'h0, 8'(i)}, v);
    end
    try(32'h4, 32'h40, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_BSIZE);
    try(32'hc, 32'h40, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_BSIZE);
    try(32'h0, 32'h40, 32'h40, 32'h104, 32'h0, dob_pkg::ERR_OALIGN);
    try(32'h0, 32'h40, 32'h40, 32'h110, 32'h0, dob_pkg::ERR_NONE);
    try(32'h1, 32'h0, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_SURF);
    try(32'h1, 32'hc0, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_SURF);
    try(32'h1, 32'h140, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_CACHE);
    try(32'h1, 32'h40, 32'h44, 32'h0, 32'h3, dob_pkg::ERR_CACHE);
    try(32'h3, 32'h40, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_WALIGN);
    try(32'h3, 32'h48, 32'h40, 32'h0, 32'h4, dob_pkg::ERR_TILE);
    try(32'h1, 32'h41, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_PALIGN);
    try(32'h1, 32'h40, 32'h40, 32'h0, 32'h3, dob_pkg::ERR_NONE);
    chk("descriptor", 32'h20000, dev_u.cap[0] & 32'h70700);
    chk("x offset", 32'h3, dev_u.cap[1]);
    chk("y offset", 32'h6, dev_u.cap[2]);
    chk("shape", 32'h70003, dev_u.cap[3]);
    try(32'h1, 32'h70, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_NONE);
    try(32'h1, 32'h270, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_STRIDE);
    wr(dob_pkg::REG_CTRL, 32'h6);
    rd(dob_pkg::REG_STATUS, v);
    chk("stride and done", 32'h80, v);
    try(32'h1, 32'h270, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_NONE);
    wr(dob_pkg::REG_BLOCK, 32'h821);
    try(32'h1, 32'h40, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_SHAPE);
    wr(dob_pkg::REG_BLOCK, 32'h4004);
    try(32'h1, 32'h40, 32'h40, 32'h0, 32'h0, dob_pkg::ERR_SIZE);
    wr(dob_pkg::REG_BLOCK, 32'h804);
    try(32'h3, 32'h458, 32'h40, 32'h0, 32'h4, dob_pkg::ERR_420POS);
    try(32'h3, 32'h458, 32'h40, 32'h0, 32'h8, dob_pkg::ERR_420BLK);
    wr(dob_pkg::REG_BLOCK, 32'h808);
    try(32'h3, 32'h458, 32'h40, 32'h0, 32'h8, dob_pkg::ERR_NONE);
    chk("length", 32'd25, 32'(dev_u.n));
    stop_test();
  end
endmodule : tb_dob_host
`default_nettype wire
